// *** rtl/hac_codec.sv ***
// Pseudo-ternary line codec top: encoder, decoder, alarm window, registers.
// Assumes encode/decode clocks and line pins are slow against the
// 100 MHz system clock and arrive asynchronously to it.
`timescale 1ns/10ps

// Operation
// - NRZ input bit is captured on the encode clock falling edge.
// - Code select one gives HDB3, zero gives plain AMI, both directions.
// - Window low clears zero count; alarm drops on 3 zeros, sets after two short windows.
// - Window high counts decoded zeros, saturating at three.
// - Error goes high on three successive same-polarity marks in HDB3.
// - Regenerated clock is OR of line inputs, or of encoder outputs in loop.
// - Positive input is positive mark, negative input negative mark; swap is harmless.
// - Line inputs are sampled on the decode clock rising edge.
// - Without loop test encoder and decoder run independently on own clocks.
// - Loop test routes encoder outputs into the matching decoder inputs.
// - Loop-back latency from NRZ in to NRZ out is seven and a half periods.
// - Line outputs are RZ pulses launched on encode rising edge, high phase long.
// - Line outputs lag their NRZ bit by three and a half encode periods.
// - Decoded NRZ lags the line inputs by three decode periods.
// - Marks alternate in polarity; spaces send no pulse except in substitutions.
// - First of four spaces stays space only when pulse parity since violation is odd.
// - Second and third of four spaces are always sent as spaces.
// - Fourth of four spaces becomes a violation pulse breaking alternation.
module hac_codec
  import hac_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              nrz_in,
  input  wire logic              enc_clk,
  input  wire logic              dec_clk,
  input  wire logic              pos_line_in,
  input  wire logic              neg_line_in,
  input  wire logic              alarm_window_strobe,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic                   nrz_out,
  output logic                   pos_line_out,
  output logic                   neg_line_out,
  output logic                   regen_clk,
  output logic                   error,
  output logic                   all_ones_alarm
);

  // Synchroniser and edge history
  logic [PIN_N-1:0]  pin_in;
  logic [PIN_N-1:0]  sync1_r;
  logic [PIN_N-1:0]  sync2_r;
  logic [PIN_N-1:0]  sync1_nxt;
  logic [PIN_N-1:0]  sync2_nxt;
  logic              enc_d_r;
  logic              enc_d_nxt;
  logic              dec_d_r;
  logic              dec_d_nxt;
  hac_win_t          win_r;
  hac_win_t          win_nxt;
  logic              nrz_s;
  logic              enc_s;
  logic              dec_s;
  logic              pos_s;
  logic              neg_s;
  logic              win_s;
  logic              dec_rise;

  // Register file
  logic [CTRL_W-1:0] ctrl_r;
  logic [CTRL_W-1:0] ctrl_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic              hdb3_mode;
  logic              loop_en;

  // Decoder
  logic [DEC_DEPTH-1:0] dly_r;
  logic [DEC_DEPTH-1:0] dly_nxt;
  logic                 nrz_r;
  logic                 nrz_nxt;
  logic                 err_r;
  logic                 err_nxt;
  logic                 lpol_r;
  logic                 lpol_nxt;
  logic                 seen_r;
  logic                 seen_nxt;
  logic [1:0]           same_r;
  logic [1:0]           same_nxt;
  logic                 regen_r;
  logic                 regen_nxt;
  logic                 mark_p;
  logic                 mark_n;
  logic                 mark;
  logic                 viol;
  logic                 lp_r;
  logic                 lp_nxt;
  logic                 ln_r;
  logic                 ln_nxt;

  // Alarm window
  logic [ZCNT_W-1:0]    zcnt_r;
  logic [ZCNT_W-1:0]    zcnt_nxt;
  logic                 alarm_r;
  logic                 alarm_nxt;
  logic                 short_r;
  logic                 short_nxt;

  hac_enc_if enc_bus ();

  // ---------------------------------------------------------------
  // Two-stage synchronisers; only stage two is ever read
  // ---------------------------------------------------------------
  assign pin_in = {nrz_in, enc_clk, dec_clk, pos_line_in, neg_line_in, alarm_window_strobe};

  always_comb begin
    sync1_nxt = pin_in;
    sync2_nxt = sync1_r;
    enc_d_nxt = enc_s;
    dec_d_nxt = dec_s;
    win_nxt   = win_s ? WIN_OPEN : WIN_CLOSED;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sync1_r <= '0;
      sync2_r <= '0;
      enc_d_r <= 1'b0;
      dec_d_r <= 1'b0;
      win_r   <= WIN_CLOSED;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      enc_d_r <= enc_d_nxt;
      dec_d_r <= dec_d_nxt;
      win_r   <= win_nxt;
    end
  end

  assign nrz_s    = sync2_r[5];
  assign enc_s    = sync2_r[4];
  assign dec_s    = sync2_r[3];
  assign pos_s    = sync2_r[2];
  assign neg_s    = sync2_r[1];
  assign win_s    = sync2_r[0];
  assign dec_rise = dec_s && !dec_d_r;

  // ---------------------------------------------------------------
  // Encoder runs on its own clock edges only
  // ---------------------------------------------------------------
  assign enc_bus.enc_rise  = enc_s && !enc_d_r;
  assign enc_bus.enc_fall  = !enc_s && enc_d_r;
  assign enc_bus.nrz_bit   = nrz_s;
  assign enc_bus.hdb3_mode = hdb3_mode;

  hac_enc u_enc (
    .clock (clock),
    .reset (reset),
    .bus   (enc_bus.enc)
  );

  assign pos_line_out = enc_bus.pos;
  assign neg_line_out = enc_bus.neg;

  // ---------------------------------------------------------------
  // Registers: control steers coding and loop, status shows decoder
  // ---------------------------------------------------------------
  assign hdb3_mode = ctrl_r[CTRL_CODE_BIT];
  assign loop_en   = ctrl_r[CTRL_LOOP_BIT];

  always_comb begin
    ctrl_nxt  = ctrl_r;
    rdata_nxt = '0;
    if (reg_wr) begin
      if (reg_addr == CTRL_OFS) begin
        ctrl_nxt = reg_wdata[CTRL_W-1:0];
      end
    end
    if (reg_rd) begin
      if (reg_addr == CTRL_OFS) begin
        rdata_nxt = {{(DATA_W-CTRL_W){1'b0}}, ctrl_r};
      end else if (reg_addr == STAT_OFS) begin
        rdata_nxt = {{(DATA_W-STAT_W){1'b0}}, zcnt_r, err_r, alarm_r};
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_r  <= CTRL_RST;
      rdata_r <= '0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ---------------------------------------------------------------
  // Decoder
  // ---------------------------------------------------------------
  assign mark_p = loop_en ? lp_r : pos_s;
  assign mark_n = loop_en ? ln_r : neg_s;
  assign mark   = mark_p || mark_n;
  assign viol   = hdb3_mode && mark && seen_r && (mark_p == lpol_r);

  always_comb begin
    dly_nxt   = dly_r;
    nrz_nxt   = nrz_r;
    err_nxt   = err_r;
    lpol_nxt  = lpol_r;
    seen_nxt  = seen_r;
    same_nxt  = same_r;
    regen_nxt = loop_en ? (enc_bus.pos || enc_bus.neg) : (pos_s || neg_s);
    // Looped pulse is gone before the next decode edge: hold it until taken
    lp_nxt    = enc_bus.pos || (lp_r && !dec_rise);
    ln_nxt    = enc_bus.neg || (ln_r && !dec_rise);
    if (dec_rise) begin
      // Violation cancels itself and the pulse three bits back
      dly_nxt = {dly_r[DEC_DEPTH-2:0], mark && !viol};
      nrz_nxt = viol ? 1'b0 : dly_r[DEC_DEPTH-1];
      if (mark) begin
        seen_nxt = 1'b1;
        lpol_nxt = mark_p;
        if (seen_r && mark_p == lpol_r) begin
          same_nxt = (same_r == 2'h3) ? same_r : same_r + 2'h1;
        end else begin
          same_nxt = 2'h1;
        end
      end
      err_nxt = hdb3_mode && mark && seen_r && mark_p == lpol_r
                && same_r >= 2'h2;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dly_r   <= '0;
      nrz_r   <= 1'b0;
      err_r   <= 1'b0;
      lpol_r  <= 1'b0;
      seen_r  <= 1'b0;
      same_r  <= 2'h0;
      regen_r <= 1'b0;
      lp_r    <= 1'b0;
      ln_r    <= 1'b0;
    end else begin
      dly_r   <= dly_nxt;
      nrz_r   <= nrz_nxt;
      err_r   <= err_nxt;
      lpol_r  <= lpol_nxt;
      seen_r  <= seen_nxt;
      same_r  <= same_nxt;
      regen_r <= regen_nxt;
      lp_r    <= lp_nxt;
      ln_r    <= ln_nxt;
    end
  end

  assign nrz_out   = nrz_r;
  assign error     = err_r;
  assign regen_clk = regen_r;

  // ---------------------------------------------------------------
  // All-ones alarm over strobe windows
  // ---------------------------------------------------------------
  always_comb begin
    zcnt_nxt  = zcnt_r;
    alarm_nxt = alarm_r;
    short_nxt = short_r;
    case (win_r)
      WIN_OPEN: begin
        if (!win_s) begin
          // Window just closed: judge it
          zcnt_nxt = '0;
          if (zcnt_r >= ALARM_MIN_ZEROS) begin
            alarm_nxt = 1'b0;
            short_nxt = 1'b0;
          end else begin
            alarm_nxt = short_r ? 1'b1 : alarm_r;
            short_nxt = 1'b1;
          end
        end else if (dec_rise && !nrz_nxt && zcnt_r != ALARM_MIN_ZEROS) begin
          zcnt_nxt = zcnt_r + 2'h1;
        end
      end
      default: begin
        zcnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      zcnt_r  <= '0;
      alarm_r <= 1'b0;
      short_r <= 1'b0;
    end else begin
      zcnt_r  <= zcnt_nxt;
      alarm_r <= alarm_nxt;
      short_r <= short_nxt;
    end
  end

  assign all_ones_alarm = alarm_r;

endmodule

// *** rtl/hac_pkg.sv ***
// Constants and types shared by the line codec modules.
// Assumes a single 100 MHz system clock; all line pins are sampled by it.
package hac_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;

  // Control register fields
  localparam int unsigned CTRL_W        = 2;
  localparam int unsigned CTRL_CODE_BIT = 0;
  localparam int unsigned CTRL_LOOP_BIT = 1;
  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h1;

  // Status register fields
  localparam int unsigned STAT_ALARM_BIT = 0;
  localparam int unsigned STAT_ERR_BIT   = 1;
  localparam int unsigned STAT_ZCNT_LSB  = 2;
  localparam int unsigned STAT_W         = 4;

  // Alarm window threshold on decoded zeros
  localparam int unsigned ZCNT_W          = 2;
  localparam logic [ZCNT_W-1:0] ALARM_MIN_ZEROS = 2'h3;

  // Pipeline depths: encoder look-ahead and decoder delay in line clocks
  localparam int unsigned ENC_DEPTH = 4;
  localparam int unsigned DEC_DEPTH = 3;

  // Number of pins passed through the synchroniser
  localparam int unsigned PIN_N = 6;

  // Encoded symbol in the encoder look-ahead line
  typedef enum logic [1:0] {
    SYM_SPACE = 2'b00,
    SYM_MARK  = 2'b01,
    SYM_VIOL  = 2'b11
  } hac_sym_t;

  // Alarm window state
  typedef enum logic {
    WIN_CLOSED = 1'b0,
    WIN_OPEN   = 1'b1
  } hac_win_t;

endpackage

// *** rtl/hac_enc_if.sv ***
// Link between the codec top and its encoder core.
// Assumes the edge pulses are one system clock long and never coincide.
`timescale 1ns/10ps
interface hac_enc_if;
  logic enc_rise;
  logic enc_fall;
  logic nrz_bit;
  logic hdb3_mode;
  logic pos;
  logic neg;

  modport enc (
    input  enc_rise,
    input  enc_fall,
    input  nrz_bit,
    input  hdb3_mode,
    output pos,
    output neg
  );

  modport top (
    output enc_rise,
    output enc_fall,
    output nrz_bit,
    output hdb3_mode,
    input  pos,
    input  neg
  );
endinterface

// *** rtl/hac_enc.sv ***
// Encoder core: NRZ to AMI or HDB3 return-to-zero pulse pair.
// Assumes edge strobes of the encode clock already synchronised.
`timescale 1ns/10ps
module hac_enc
  import hac_pkg::*;
(
  input  wire logic clock,
  input  wire logic reset,
  hac_enc_if.enc    bus
);

  hac_sym_t [ENC_DEPTH-1:0] line_r;
  hac_sym_t [ENC_DEPTH-1:0] line_nxt;
  logic                     par_r;
  logic                     par_nxt;
  logic                     pol_r;
  logic                     pol_nxt;
  logic                     pos_r;
  logic                     pos_nxt;
  logic                     neg_r;
  logic                     neg_nxt;
  logic                     sub;

  always_comb begin
    line_nxt = line_r;
    par_nxt  = par_r;
    pol_nxt  = pol_r;
    pos_nxt  = pos_r;
    neg_nxt  = neg_r;
    sub      = bus.hdb3_mode && !bus.nrz_bit && line_r[0] == SYM_SPACE
               && line_r[1] == SYM_SPACE && line_r[2] == SYM_SPACE;
    if (bus.enc_fall) begin
      // Capture and look ahead over four bits
      line_nxt[0] = bus.nrz_bit ? SYM_MARK : (sub ? SYM_VIOL : SYM_SPACE);
      line_nxt[1] = line_r[0];
      line_nxt[2] = line_r[1];
      line_nxt[3] = (sub && !par_r) ? SYM_MARK : line_r[2];
      pos_nxt     = 1'b0;
      neg_nxt     = 1'b0;
    end else if (bus.enc_rise) begin
      // Launch oldest symbol for the high phase
      case (line_r[3])
        SYM_MARK: begin
          pol_nxt = ~pol_r;
          par_nxt = ~par_r;
          pos_nxt = ~pol_r;
          neg_nxt = pol_r;
        end
        SYM_VIOL: begin
          par_nxt = 1'b0;
          pos_nxt = pol_r;
          neg_nxt = ~pol_r;
        end
        default: begin
          pos_nxt = 1'b0;
          neg_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      line_r <= '{default: SYM_SPACE};
      par_r  <= 1'b0;
      pol_r  <= 1'b0;
      pos_r  <= 1'b0;
      neg_r  <= 1'b0;
    end else begin
      line_r <= line_nxt;
      par_r  <= par_nxt;
      pol_r  <= pol_nxt;
      pos_r  <= pos_nxt;
      neg_r  <= neg_nxt;
    end
  end

  assign bus.pos = pos_r;
  assign bus.neg = neg_r;

endmodule

// *** verification/hac_codec_assertions.sv ***
// Port checker for the codec top.
// Assumes encode, decode and window pins are slow against clock.
`timescale 1ns/10ps
module hac_codec_assertions
  import hac_pkg::*;
(
  input wire logic              clock,
  input wire logic              reset,
  input wire logic              enc_clk,
  input wire logic              dec_clk,
  input wire logic              alarm_window_strobe,
  input wire logic              pos_line_in,
  input wire logic              neg_line_in,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              nrz_out,
  input wire logic              pos_line_out,
  input wire logic              neg_line_out,
  input wire logic              regen_clk,
  input wire logic              error,
  input wire logic              all_ones_alarm
);
  logic [7:0] eh, dh, wh, oh;
  // Short pin histories to allow for synchroniser delay
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      eh <= '0;
      dh <= '0;
      wh <= '0;
      oh <= '0;
    end else begin
      eh <= {eh[6:0], enc_clk};
      dh <= {dh[6:0], dec_clk};
      wh <= {wh[6:0], alarm_window_strobe};
      oh <= {oh[6:0], pos_line_in | neg_line_in | pos_line_out | neg_line_out};
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_dec_edge;
    |(dh[6:1] & ~dh[7:2]);
  endsequence
  sequence s_win_close;
    |(wh[7:2] & ~wh[6:1]);
  endsequence
  chk_never_both: assert property (!(pos_line_out && neg_line_out))
    else $error("both line outputs high");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside answer cycle");
  chk_rz_phase: assert property (pos_line_out || neg_line_out |-> |eh)
    else $error("line pulse outside encode high phase");
  chk_regen_src: assert property (regen_clk |-> |oh || pos_line_out || neg_line_out)
    else $error("regenerated clock without pulse");
  chk_nrz_edge: assert property ($changed(nrz_out) |-> s_dec_edge)
    else $error("decoded data moved off decode edge");
  chk_err_edge: assert property ($changed(error) |-> s_dec_edge)
    else $error("error moved off decode edge");
  chk_alarm_win: assert property ($changed(all_ones_alarm) |-> s_win_close)
    else $error("alarm moved outside window close");
  chk_alarm_hold: assert property (wh == 8'hff |-> $stable(all_ones_alarm))
    else $error("alarm moved while window open");
endmodule
bind hac_codec hac_codec_assertions i_hac_codec_assertions (
  .clock, .reset, .enc_clk, .dec_clk, .alarm_window_strobe,
  .pos_line_in, .neg_line_in, .reg_rd, .reg_rdata, .nrz_out,
  .pos_line_out, .neg_line_out, .regen_clk, .error, .all_ones_alarm
);

// *** verification/hac_line_src.sv ***
// Far-side line source feeding the decoder inputs.
// Assumes one symbol per decode clock period, idle as spaces.
`timescale 1ns/10ps
module hac_line_src (
  input  wire logic dec_clk,
  input  wire logic swap,
  output logic      pos_line_in,
  output logic      neg_line_in
);
  int sq[$];
  initial begin
    pos_line_in = 1'b0;
    neg_line_in = 1'b0;
  end
  // New symbol on the falling edge, held over the sampling rise
  always @(negedge dec_clk) begin
    int s;
    s = (sq.size() > 0) ? sq.pop_front() : 0;
    pos_line_in <= swap ? (s < 0) : (s > 0);
    neg_line_in <= swap ? (s > 0) : (s < 0);
  end
endmodule

// *** verification/test_hac_codec.sv ***
// Self-checking bench for the codec top.
// Assumes one line clock drives encode and decode, 20 clocks a period.
`timescale 1ns/10ps
module test_hac_codec import hac_pkg::*;;
  logic              clock = 1'b0;
  logic              reset = 1'b1;
  logic              nrz_in = 1'b0;
  logic              enc_clk = 1'b0;
  logic              swap = 1'b0;
  logic              alarm_window_strobe = 1'b0;
  logic              pos_line_in, neg_line_in;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic              nrz_out, pos_line_out, neg_line_out, regen_clk, error, all_ones_alarm;
  int                cnt = 0, per = 0, cycles = 0, errors = 0, n_checks = 0;
  logic              tx[$];
  logic [1:0]        sym_log[1024];
  logic              nrz_log[1024];
  logic              err_log[1024];
  logic              rgn_log[1024];

  hac_codec i_hac_codec (
    .clock, .reset, .nrz_in, .enc_clk,
    .dec_clk(enc_clk),
    .pos_line_in, .neg_line_in, .alarm_window_strobe, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .nrz_out, .pos_line_out, .neg_line_out,
    .regen_clk, .error, .all_ones_alarm
  );
  hac_line_src i_hac_line_src (.dec_clk(enc_clk), .swap, .pos_line_in, .neg_line_in);

  always #5 clock = ~clock;

  always @(posedge clock) begin
    cycles <= cycles + 1;
    cnt <= (cnt == 19) ? 0 : cnt + 1;
    enc_clk <= (cnt == 19) || (cnt < 9);
    if (cnt == 19) begin
      per <= per + 1;
      nrz_in <= (tx.size() > 0) ? tx.pop_front() : 1'b0;
    end
    if (cnt == 7) begin
      sym_log[per] <= {pos_line_out, neg_line_out};
      nrz_log[per] <= nrz_out;
      err_log[per] <= error;
      rgn_log[per] <= regen_clk;
    end
    if (cycles == 20000) begin
      errors = errors + 1;
      finish_test();
    end
  end

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
    @(posedge clock);
  endtask
  task automatic wt(input int k);
    repeat (20 * k) @(posedge clock);
  endtask
  task automatic sync(input int c);
    while (cnt != c) @(posedge clock);
  endtask

  task automatic t_regs;
    logic [31:0] v;
    rd(CTRL_OFS, v);
    check("ctrl reset", v, 32'(CTRL_RST));
    wr(CTRL_OFS, 32'hffff_fffe);
    rd(CTRL_OFS, v);
    check("ctrl rw", v, 32'h2);
    wr(STAT_OFS, 32'hffff_ffff);
    rd(CTRL_OFS, v);
    check("ctrl kept", v, 32'h2);
    rd(8'h08, v);
    check("unmapped", v, 32'h0);
  endtask

  task automatic t_enc(input logic [1:0] ctrl);
    logic b[22] = '{1, 1, 0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 1, 0, 1, 0, 0, 0, 0};
    int e[22];
    int pol, nb, i, p0;
    pol = -1;
    nb = 0;
    i = 0;
    while (i < 22) begin
      if (ctrl[0] && i < 19 && !(b[i] | b[i+1] | b[i+2] | b[i+3])) begin
        e[i] = (nb % 2 == 0) ? -pol : 0;
        if (nb % 2 == 0) pol = -pol;
        e[i+1] = 0;
        e[i+2] = 0;
        e[i+3] = pol;
        nb = 0;
        i += 4;
      end else begin
        if (b[i]) pol = -pol;
        e[i] = b[i] ? pol : 0;
        nb += b[i];
        i++;
      end
    end
    reset <= 1'b1;
    wt(1);
    sync(17);
    foreach (b[k]) tx.push_back(b[k]);
    sync(0);
    p0 = per;
    reset <= 1'b0;
    wr(CTRL_OFS, 32'(ctrl));
    wt(34);
    for (int k = 0; k < 22; k++) begin
      check("line", 32'(sym_log[p0+4+k]), 32'({e[k] > 0, e[k] < 0}));
      if (ctrl[1]) check("loop nrz", 32'(nrz_log[p0+8+k]), 32'(b[k]));
      if (ctrl[1]) check("loop error", 32'(err_log[p0+8+k]), 32'h0);
      check("regen", 32'(rgn_log[p0+4+k]), 32'(ctrl[1] && e[k] != 0));
    end
  endtask

  task automatic t_dec(input logic [1:0] ctrl, input logic sw);
    int s[6] = '{-1, 1, 1, 1, 0, -1};
    int p0;
    logic [3:0] n;
    wr(CTRL_OFS, 32'(ctrl));
    swap <= sw;
    sync(1);
    p0 = per;
    foreach (s[k]) i_hac_line_src.sq.push_back(s[k]);
    wt(12);
    n = 4'h0;
    for (int k = p0; k < p0 + 12; k++) n = n + 4'(err_log[k]);
    check("error count", 32'(n), 32'(ctrl[0]));
    for (int k = 0; k < 6 && !ctrl[0]; k++) check("nrz", 32'(nrz_log[p0+4+k]), 32'(s[k] != 0));
    for (int k = 0; k < 6; k++) check("regen", 32'(rgn_log[p0+1+k]), 32'(s[k] != 0));
  endtask

  task automatic t_alarm;
    logic [31:0] v;
    wr(CTRL_OFS, 32'h0);
    sync(1);
    repeat (15) begin
      i_hac_line_src.sq.push_back(1);
      i_hac_line_src.sq.push_back(-1);
    end
    wt(6);
    repeat (2) begin
      alarm_window_strobe <= 1'b1;
      wt(8);
      alarm_window_strobe <= 1'b0;
      wt(1);
    end
    check("alarm set", 32'(all_ones_alarm), 32'h1);
    rd(STAT_OFS, v);
    check("status alarm", 32'(v[0]), 32'h1);
    check("count cleared", 32'(v[3:2]), 32'h0);
    wt(12);
    alarm_window_strobe <= 1'b1;
    wt(6);
    rd(STAT_OFS, v);
    check("zero count", 32'(v[3:2]), 32'h3);
    alarm_window_strobe <= 1'b0;
    wt(1);
    check("alarm clear", 32'(all_ones_alarm), 32'h0);
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    t_regs;
    t_enc(2'h0);
    t_enc(2'h1);
    t_enc(2'h3);
    t_enc(2'h2);
    t_dec(2'h0, 1'b1);
    t_dec(2'h1, 1'b0);
    t_alarm;
    finish_test;
  end
endmodule
